// file: src/dsg_clock_gate_bank.sv
// Deep-sleep clock gate bank with its run and sleep companions
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module dsg_clock_gate_bank
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Register port
   input wire dsg_pkg::dsg_bus_req_s bus_req,
   output logic [31:0] bus_rdata,
   // Power mode requests from the power controller
   input wire logic sleep_req,
   input wire logic deep_sleep_req,
   // Peripheral access check
   input wire dsg_pkg::dsg_unit_acc_s unit_acc,
   output dsg_pkg::dsg_unit_rsp_s unit_rsp,
   // Clock enables to the units and mode in force
   output logic [31:0] unit_clk_en,
   output dsg_pkg::dsg_mode_e active_mode,
   // Interrupt
   output logic irq
);
   import dsg_pkg::*;

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   wire logic hit_cfg;
   wire logic hit_run;
   wire logic hit_sleep;
   wire logic hit_deep;
   wire logic hit_status;
   wire logic hit_mask;
   wire logic hit_active;
   wire logic hit_mode;
   wire logic wr_cfg;
   wire logic wr_run;
   wire logic wr_sleep;
   wire logic wr_deep;
   wire logic wr_status;
   wire logic wr_mask;

   assign hit_cfg = bus_req.addr == OFS_RUN_CFG;
   assign hit_run = bus_req.addr == OFS_RUN_GATE1;
   assign hit_sleep = bus_req.addr == OFS_SLEEP_GATE1;
   assign hit_deep = bus_req.addr == OFS_DEEP_GATE1;
   assign hit_status = bus_req.addr == OFS_IRQ_STATUS;
   assign hit_mask = bus_req.addr == OFS_IRQ_MASK;
   assign hit_active = bus_req.addr == OFS_ACTIVE_GATE;
   assign hit_mode = bus_req.addr == OFS_MODE_STATUS;
   assign wr_cfg = bus_req.wr & hit_cfg;
   assign wr_run = bus_req.wr & hit_run;
   assign wr_sleep = bus_req.wr & hit_sleep;
   assign wr_deep = bus_req.wr & hit_deep;
   assign wr_status = bus_req.wr & hit_status;
   assign wr_mask = bus_req.wr & hit_mask;

   // ------------------------------------------------------------
   // Gate registers
   // ------------------------------------------------------------
   logic [31:0] run_gate_q;
   logic [31:0] sleep_gate_q;
   logic [31:0] deep_gate_q;
   logic [31:0] run_cfg_q;
   logic [31:0] run_gate_d;
   logic [31:0] sleep_gate_d;
   logic [31:0] deep_gate_d;
   logic [31:0] run_cfg_d;
   wire logic auto_gate_sel;

   // Only implemented gate bits are stored; the rest stay zero
   function automatic logic [31:0] gate_field(input logic [31:0] wdata);
      gate_field = wdata & GATE_WR_MASK;
   endfunction

   assign run_gate_d = wr_run ? gate_field(bus_req.wdata) : run_gate_q;
   assign sleep_gate_d = wr_sleep ? gate_field(bus_req.wdata) : sleep_gate_q;
   assign deep_gate_d = wr_deep ? gate_field(bus_req.wdata) : deep_gate_q;
   assign run_cfg_d = wr_cfg ? (bus_req.wdata & CFG_WR_MASK) : run_cfg_q;
   assign auto_gate_sel = run_cfg_q[CFG_AUTO_GATE_BIT];

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         run_gate_q <= GATE_RESET;
         sleep_gate_q <= GATE_RESET;
         deep_gate_q <= GATE_RESET;
         run_cfg_q <= CFG_RESET;
      end
      else
      begin
         run_gate_q <= run_gate_d;
         sleep_gate_q <= sleep_gate_d;
         deep_gate_q <= deep_gate_d;
         run_cfg_q <= run_cfg_d;
      end
   end

   // ------------------------------------------------------------
   // Mode tracking and gate selection
   // ------------------------------------------------------------
   dsg_mode_e mode_q;
   dsg_mode_e mode_d;
   logic [31:0] sel_gate;
   logic [31:0] clk_en_q;
   wire logic gate_changed;

   // Deep-sleep outranks sleep when both are asserted
   assign mode_d = deep_sleep_req ? DSG_MODE_DEEP :
                   sleep_req ? DSG_MODE_SLEEP : DSG_MODE_RUN;

   // Without auto gating the run settings stay in force in every mode
   always_comb
   begin
      unique case (mode_q)
         DSG_MODE_RUN: sel_gate = run_gate_q;
         DSG_MODE_SLEEP: sel_gate = auto_gate_sel ? sleep_gate_q : run_gate_q;
         DSG_MODE_DEEP: sel_gate = auto_gate_sel ? deep_gate_q : run_gate_q;
         default: sel_gate = run_gate_q;
      endcase
   end

   assign gate_changed = sel_gate != clk_en_q;

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         mode_q <= DSG_MODE_RUN;
         clk_en_q <= GATE_RESET;
      end
      else
      begin
         mode_q <= mode_d;
         clk_en_q <= sel_gate;
      end
   end

   assign unit_clk_en = clk_en_q;
   assign active_mode = mode_q;

   // ------------------------------------------------------------
   // Access check against the clocks in force
   // ------------------------------------------------------------
   dsg_unit_rsp_s chk_rsp;

   dsg_fault_check u_fault_check
   (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .gate_en(clk_en_q),
      .unit_acc(unit_acc),
      .unit_rsp(chk_rsp)
   );

   assign unit_rsp = chk_rsp;

   // ------------------------------------------------------------
   // Interrupt status and mask
   // ------------------------------------------------------------
   logic [IRQ_W-1:0] irq_status_q;
   logic [IRQ_W-1:0] irq_status_d;
   logic [IRQ_W-1:0] irq_mask_q;
   logic [IRQ_W-1:0] irq_mask_d;
   logic [IRQ_W-1:0] irq_events;
   logic [IRQ_W-1:0] irq_clear;

   assign irq_events[IRQ_FAULT_BIT] = chk_rsp.fault;
   assign irq_events[IRQ_CHANGE_BIT] = gate_changed;
   assign irq_clear = wr_status ? bus_req.wdata[IRQ_W-1:0] : IRQ_RESET;
   // A new event in the clearing cycle survives the clear
   assign irq_status_d = (irq_status_q & ~irq_clear) | irq_events;
   assign irq_mask_d = wr_mask ? bus_req.wdata[IRQ_W-1:0] : irq_mask_q;
   assign irq = |(irq_status_q & irq_mask_q);

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         irq_status_q <= IRQ_RESET;
         irq_mask_q <= IRQ_RESET;
      end
      else
      begin
         irq_status_q <= irq_status_d;
         irq_mask_q <= irq_mask_d;
      end
   end

   // ------------------------------------------------------------
   // Read path
   // ------------------------------------------------------------
   logic [31:0] rd_value;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   // Unmapped offsets and reserved bits read as zero
   assign rd_value = hit_cfg ? run_cfg_q :
                     hit_run ? run_gate_q :
                     hit_sleep ? sleep_gate_q :
                     hit_deep ? deep_gate_q :
                     hit_status ? {30'h0, irq_status_q} :
                     hit_mask ? {30'h0, irq_mask_q} :
                     hit_active ? clk_en_q :
                     hit_mode ? {30'h0, mode_q} : 32'h0;
   assign rdata_d = bus_req.rd ? rd_value : 32'h0;
   assign bus_rdata = rdata_q;

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         rdata_q <= 32'h0;
      else
         rdata_q <= rdata_d;
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   logic seen_clk_q;

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         seen_clk_q <= 1'b0;
      else
         seen_clk_q <= 1'b1;
   end

   sequence s_deep_write;
      wr_deep;
   endsequence

   sequence s_deep_read;
      bus_req.rd && hit_deep;
   endsequence

   sequence s_deep_in_force;
      mode_q == DSG_MODE_DEEP && auto_gate_sel;
   endsequence

   chk_reset_all_clear: assert property (@(posedge core_clk) disable iff (!reset_n)
      !seen_clk_q |-> deep_gate_q == GATE_RESET && run_gate_q == GATE_RESET
                      && sleep_gate_q == GATE_RESET && unit_clk_en == GATE_RESET)
      else $error("gate state not clear after reset");

   chk_deep_write_store: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_deep_write |=> deep_gate_q == ($past(bus_req.wdata) & GATE_WR_MASK))
      else $error("deep-sleep gate write not stored");

   chk_comp_bits: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_deep_write |=> deep_gate_q[BIT_COMPARATOR1:BIT_COMPARATOR0]
                       == $past(bus_req.wdata[BIT_COMPARATOR1:BIT_COMPARATOR0]))
      else $error("comparator gate bits wrong");

   chk_counter_bits: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_deep_write |=> deep_gate_q[BIT_GPCNT2:BIT_GPCNT0]
                       == $past(bus_req.wdata[BIT_GPCNT2:BIT_GPCNT0]))
      else $error("counter gate bits wrong");

   chk_serial_bits: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_deep_write |=> {deep_gate_q[BIT_TWO_WIRE0], deep_gate_q[BIT_SYNC_SER0],
                        deep_gate_q[BIT_ASYNC1:BIT_ASYNC0]}
                       == $past({bus_req.wdata[BIT_TWO_WIRE0], bus_req.wdata[BIT_SYNC_SER0],
                                 bus_req.wdata[BIT_ASYNC1:BIT_ASYNC0]}))
      else $error("serial unit gate bits wrong");

   chk_reserved_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_deep_read |=> bus_rdata == $past(deep_gate_q) && (bus_rdata & ~GATE_WR_MASK) == 32'h0)
      else $error("deep-sleep gate readback wrong");

   chk_deep_applies: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_deep_in_force |=> unit_clk_en == $past(deep_gate_q))
      else $error("deep-sleep gates not in force");

   chk_run_applies: assert property (@(posedge core_clk) disable iff (!reset_n)
      mode_q == DSG_MODE_RUN |=> unit_clk_en == $past(run_gate_q))
      else $error("run gates not in force");

   chk_auto_required: assert property (@(posedge core_clk) disable iff (!reset_n)
      mode_q != DSG_MODE_RUN && !auto_gate_sel |=> unit_clk_en == $past(run_gate_q))
      else $error("sleep gates used without auto gating");

   chk_regs_apart: assert property (@(posedge core_clk) disable iff (!reset_n)
      wr_sleep || wr_run |=> $stable(deep_gate_q))
      else $error("deep-sleep gate disturbed by another register");

   chk_clock_follows: assert property (@(posedge core_clk) disable iff (!reset_n)
      wr_run && mode_q == DSG_MODE_RUN && mode_d == DSG_MODE_RUN
      |=> ##1 unit_clk_en == ($past(bus_req.wdata, 2) & GATE_WR_MASK))
      else $error("clock enable did not follow run gate write");

   // ------------------------------------------------------------
   // Read path, mode and interrupt checks
   // ------------------------------------------------------------
   sequence s_stray_read;
      bus_req.rd && !(hit_cfg || hit_run || hit_sleep || hit_deep)
      && !(hit_status || hit_mask || hit_active || hit_mode);
   endsequence

   sequence s_sleep_in_force;
      mode_q == DSG_MODE_SLEEP && auto_gate_sel;
   endsequence

   sequence s_fault_clear;
      wr_status && bus_req.wdata[IRQ_FAULT_BIT] && !chk_rsp.fault;
   endsequence

   chk_read_idle_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
      !bus_req.rd |=> bus_rdata == 32'h0)
      else $error("read data outside the answer cycle");

   chk_stray_read_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_stray_read |=> bus_rdata == 32'h0)
      else $error("unmapped offset did not read zero");

   chk_sleep_applies: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_sleep_in_force |=> unit_clk_en == $past(sleep_gate_q))
      else $error("sleep gates not in force");

   chk_deep_mode_taken: assert property (@(posedge core_clk) disable iff (!reset_n)
      deep_sleep_req |=> active_mode == DSG_MODE_DEEP)
      else $error("deep-sleep request not taken");

   chk_sleep_mode_taken: assert property (@(posedge core_clk) disable iff (!reset_n)
      sleep_req && !deep_sleep_req |=> active_mode == DSG_MODE_SLEEP)
      else $error("sleep request not taken");

   chk_fault_status: assert property (@(posedge core_clk) disable iff (!reset_n)
      chk_rsp.fault |=> irq_status_q[IRQ_FAULT_BIT])
      else $error("fault did not set its status bit");

   chk_fault_cleared: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_fault_clear |=> !irq_status_q[IRQ_FAULT_BIT])
      else $error("fault status bit not cleared");

   chk_change_status: assert property (@(posedge core_clk) disable iff (!reset_n)
      gate_changed |=> irq_status_q[IRQ_CHANGE_BIT])
      else $error("enable change did not set its status bit");
endmodule

// file: src/dsg_fault_check.sv
// Access check that turns accesses to unclocked units into bus faults
`timescale 1ns/1ps
module dsg_fault_check
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Clock enables in force
   input wire logic [31:0] gate_en,
   // Unit access and answer
   input wire dsg_pkg::dsg_unit_acc_s unit_acc,
   output dsg_pkg::dsg_unit_rsp_s unit_rsp
);
   import dsg_pkg::*;

   dsg_unit_rsp_s rsp_q;
   dsg_unit_rsp_s rsp_d;
   wire logic unit_on;

   // Reserved positions are never clocked, so they always fault
   function automatic logic unit_clocked(input logic [31:0] en, input logic [4:0] idx);
      unit_clocked = en[idx] & GATE_WR_MASK[idx];
   endfunction

   assign unit_on = unit_clocked(gate_en, unit_acc.unit);
   assign rsp_d.done = unit_acc.req & unit_on;
   assign rsp_d.fault = unit_acc.req & ~unit_on;
   assign unit_rsp = rsp_q;

   always_ff @(posedge core_clk or negedge reset_n)
   begin
      if (!reset_n)
         rsp_q <= '0;
      else
         rsp_q <= rsp_d;
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_gated_access;
      unit_acc.req && !gate_en[unit_acc.unit];
   endsequence

   chk_fault_gated: assert property (@(posedge core_clk) disable iff (!reset_n)
      s_gated_access |=> unit_rsp.fault && !unit_rsp.done)
      else $error("access to unclocked unit did not fault");

   chk_grant_clocked: assert property (@(posedge core_clk) disable iff (!reset_n)
      unit_acc.req && unit_clocked(gate_en, unit_acc.unit) |=> unit_rsp.done && !unit_rsp.fault)
      else $error("access to clocked unit was not completed");

   chk_idle_quiet: assert property (@(posedge core_clk) disable iff (!reset_n)
      !unit_acc.req |=> !unit_rsp.done && !unit_rsp.fault)
      else $error("answer without access");
endmodule

// file: src/dsg_pkg.sv
// Shared constants and types for the deep-sleep clock gate bank
package dsg_pkg;
   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam int ADDR_W = 12;
   localparam logic [31:0] SYSCTL_BASE = 32'h400f_e000;
   localparam logic [11:0] OFS_RUN_CFG = 12'h060;
   localparam logic [11:0] OFS_RUN_GATE1 = 12'h104;
   localparam logic [11:0] OFS_SLEEP_GATE1 = 12'h114;
   localparam logic [11:0] OFS_DEEP_GATE1 = 12'h124;
   localparam logic [11:0] OFS_IRQ_STATUS = 12'h180;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h184;
   localparam logic [11:0] OFS_ACTIVE_GATE = 12'h188;
   localparam logic [11:0] OFS_MODE_STATUS = 12'h18c;

   // ------------------------------------------------------------
   // Gate register fields
   // ------------------------------------------------------------
   localparam int BIT_COMPARATOR1 = 25;
   localparam int BIT_COMPARATOR0 = 24;
   localparam int BIT_GPCNT2 = 18;
   localparam int BIT_GPCNT1 = 17;
   localparam int BIT_GPCNT0 = 16;
   localparam int BIT_TWO_WIRE0 = 12;
   localparam int BIT_SYNC_SER0 = 4;
   localparam int BIT_ASYNC1 = 1;
   localparam int BIT_ASYNC0 = 0;
   localparam logic [31:0] GATE_WR_MASK = 32'h0307_1013;
   localparam logic [31:0] GATE_RESET = 32'h0000_0000;

   // ------------------------------------------------------------
   // Configuration, interrupt and status fields
   // ------------------------------------------------------------
   localparam int CFG_AUTO_GATE_BIT = 27;
   localparam logic [31:0] CFG_WR_MASK = 32'h0800_0000;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam int IRQ_W = 2;
   localparam int IRQ_FAULT_BIT = 0;
   localparam int IRQ_CHANGE_BIT = 1;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0]
   {
      DSG_MODE_RUN = 2'b00,
      DSG_MODE_SLEEP = 2'b01,
      DSG_MODE_DEEP = 2'b10
   } dsg_mode_e;

   typedef struct packed
   {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [31:0] wdata;
   } dsg_bus_req_s;

   typedef struct packed
   {
      logic req;
      logic [4:0] unit;
   } dsg_unit_acc_s;

   typedef struct packed
   {
      logic done;
      logic fault;
   } dsg_unit_rsp_s;
endpackage

// file: testbench/dsg_clock_gate_bank_tb_top.sv
// Self-checking bench for the deep-sleep clock gate bank
`timescale 1ns/1ps
module dsg_clock_gate_bank_tb_top;
   import dsg_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic core_clk = 1'b0;
   logic reset_n = 1'b0;
   dsg_bus_req_s bus_req = '0;
   logic [31:0] bus_rdata;
   logic sleep_req = 1'b0;
   logic deep_sleep_req = 1'b0;
   dsg_unit_acc_s unit_acc = '0;
   dsg_unit_rsp_s unit_rsp;
   logic [31:0] unit_clk_en;
   dsg_mode_e active_mode;
   logic irq;
   int bad_count = 0;
   int n_tests = 0;
   logic [31:0] lfsr_q = 32'h0000_0060;
   logic [31:0] rd_val;
   logic [31:0] v;
   logic [31:0] run_m;
   logic [31:0] slp_m;
   logic [31:0] deep_m;

   always #2.5 core_clk = ~core_clk;

   dsg_clock_gate_bank uut
   (
      .core_clk(core_clk),
      .reset_n(reset_n),
      .bus_req(bus_req),
      .bus_rdata(bus_rdata),
      .sleep_req(sleep_req),
      .deep_sleep_req(deep_sleep_req),
      .unit_acc(unit_acc),
      .unit_rsp(unit_rsp),
      .unit_clk_en(unit_clk_en),
      .active_mode(active_mode),
      .irq(irq)
   );

   // ------------------------------------------------------------
   // Expectations and helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Without the auto bit the run word governs every mode
   function automatic logic [31:0] exp_en(input logic auto_on, input logic s, input logic d);
      if (!auto_on || (!s && !d))
         return run_m;
      return d ? deep_m : slp_m;
   endfunction

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge core_clk);
      bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge core_clk);
      bus_req <= '0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      @(posedge core_clk);
      bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
      @(posedge core_clk);
      bus_req <= '0;
      #1;
      d = bus_rdata;
   endtask

   task automatic acc(input logic [4:0] idx, input logic f);
      @(posedge core_clk);
      unit_acc <= '{req: 1'b1, unit: idx};
      @(posedge core_clk);
      unit_acc <= '0;
      #1;
      check("unit answer", {30'h0, unit_rsp.done, unit_rsp.fault}, {30'h0, !f, f});
   endtask

   task automatic set_mode(input logic s, input logic d);
      @(posedge core_clk);
      sleep_req <= s;
      deep_sleep_req <= d;
      settle(2);
   endtask

   task automatic rnd;
      lfsr_q = lfsr_next(lfsr_q);
   endtask

   // ------------------------------------------------------------
   // Hang guard
   // ------------------------------------------------------------
   initial
   begin
      repeat (20000) @(posedge core_clk);
      bad_count++;
      $display("BAD watchdog expired");
      finish_test();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      repeat (16) @(posedge core_clk);
      reset_n <= 1'b1;
      rd(12'h124, rd_val);
      check("deep word reset", rd_val, 32'h0000_0000);
      check("enables reset", unit_clk_en, 32'h0);
      check("irq reset", {31'h0, irq}, 32'h0);
      $display("test reset done");

      // Corner words first, then random ones
      for (int i = 0; i < 12; i++)
      begin
         rnd();
         v = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : lfsr_q;
         wr(12'h124, v);
         rd(12'h124, rd_val);
         check("deep word", rd_val, v & 32'h0307_1013);
         wr(OFS_SLEEP_GATE1, ~v);
         rd(OFS_SLEEP_GATE1, rd_val);
         check("sleep word", rd_val, ~v & 32'h0307_1013);
      end
      rd(12'h128, rd_val);
      check("unmapped read", rd_val, 32'h0);
      $display("test register access done");

      // Distinct words so a wrong selection shows
      rnd();
      run_m = lfsr_q & GATE_WR_MASK;
      slp_m = ~run_m & GATE_WR_MASK;
      rnd();
      deep_m = (lfsr_q & GATE_WR_MASK) | 32'h0100_0001;
      wr(OFS_RUN_GATE1, run_m);
      wr(OFS_SLEEP_GATE1, slp_m);
      wr(OFS_DEEP_GATE1, deep_m);
      for (int k = 0; k < 8; k++)
      begin
         wr(OFS_RUN_CFG, {4'h0, k[2], 27'h0});
         set_mode(k[0], k[1]);
         check("enables", unit_clk_en, exp_en(k[2], k[0], k[1]));
         v = k[1] ? 32'(DSG_MODE_DEEP) : k[0] ? 32'(DSG_MODE_SLEEP) : 32'(DSG_MODE_RUN);
         check("mode", 32'(active_mode), v);
         rd(OFS_ACTIVE_GATE, rd_val);
         check("enables word", rd_val, exp_en(k[2], k[0], k[1]));
         rd(OFS_MODE_STATUS, rd_val);
         check("mode word", rd_val, v);
      end
      $display("test mode selection done");

      // Deep-sleep in force, every unit accessed and expected to fault where the deep word bit is clear
      wr(OFS_RUN_CFG, 32'h0800_0000);
      set_mode(1'b1, 1'b1);
      wr(OFS_IRQ_MASK, 32'h0);
      wr(OFS_IRQ_STATUS, 32'h3);
      for (int i = 0; i < 32; i++)
         acc(i[4:0], !deep_m[i]);
      settle(1);
      check("fault masked irq", {31'h0, irq}, 32'h0);
      rd(OFS_IRQ_STATUS, rd_val);
      check("fault status", rd_val & 32'h1, 32'h1);
      wr(OFS_IRQ_MASK, 32'h1);
      #1;
      check("fault irq", {31'h0, irq}, 32'h1);
      wr(OFS_IRQ_STATUS, 32'h1);
      #1;
      check("irq cleared", {31'h0, irq}, 32'h0);
      $display("test unit access done");

      // A deep word write reaches the enables two edges on
      wr(OFS_IRQ_STATUS, 32'h3);
      rnd();
      // Bit 24 cleared so the new word always differs from the one in force
      deep_m = lfsr_q & GATE_WR_MASK & ~32'h0100_0000;
      wr(OFS_DEEP_GATE1, deep_m);
      settle(1);
      check("enables follow write", unit_clk_en, deep_m);
      rd(OFS_IRQ_STATUS, rd_val);
      check("change status", rd_val & 32'h2, 32'h2);
      acc(5'd16, !deep_m[16]);
      $display("test deep write done");

      // Second reset in mid-run
      @(posedge core_clk);
      reset_n <= 1'b0;
      settle(1);
      check("enables mid reset", unit_clk_en, 32'h0);
      @(posedge core_clk);
      reset_n <= 1'b1;
      rd(12'h124, rd_val);
      check("deep word mid reset", rd_val, 32'h0);
      acc(5'd0, 1'b1);
      $display("test second reset done");
      finish_test();
   end
endmodule
